// ===== core/drive_run_defs.vh
// constants for the run-command, dwell and slip-compensation logic
// assumes: included by bare name from every design file of this block
`ifndef DRIVE_RUN_DEFS_VH
`define DRIVE_RUN_DEFS_VH

`define CLK_HZ 20000000
`define FUNC_THREE_WIRE 5'h11
`define CTRL_SLIP_COMP 2'h1
`define INERTIA_LOW 2'h0
`define INERTIA_TEN 2'h1
`define INERTIA_HIGH 2'h2
// dwell time setting is in 0.1 s units
`define DWELL_TICK_MS 100
`define DWELL_TICK_CYC ((`CLK_HZ / 1000) * `DWELL_TICK_MS)
// three-wire minimum pulse, milliseconds
`define PULSE_MIN_MS 50
`define PULSE_MIN_CYC ((`CLK_HZ / 1000) * `PULSE_MIN_MS)
`define STANDARD_IO_TERMINALS 3
`define ADVANCED_IO_TERMINALS 5
`define CAP_CODE_W 5
`define CAP_CODE_MAX 5'h16
// full load in percent, divisor of the slip product
`define LOAD_FULL_PCT 20'h00064

`endif

// ===== core/motor_defaults.v
// motor-capacity to default nameplate data lookup
// assumes: capacity code in 0.1 kW steps, 1 means 0.1 kW, 22 means 2.2 kW
`timescale 1ns/1ns
`include "drive_run_defs.vh"

module motor_defaults (
  // selection
  input wire [4:0] motor_capacity_select,
  // defaults, current in 0.1 A, slip in 0.01 Hz, efficiency in percent
  output reg [10:0] motor_rated_current,
  output reg [9:0] rated_slip_frequency,
  output reg [9:0] no_load_current,
  output reg [6:0] motor_efficiency_setting
);

  // plain scaling laws stand in for a per-size table; small motors slip more
  always @* begin
    if (motor_capacity_select == 5'h00 ||
        motor_capacity_select > `CAP_CODE_MAX) begin
      motor_rated_current = 11'h006;
      rated_slip_frequency = 10'h0C8;
      no_load_current = 10'h004;
      motor_efficiency_setting = 7'h3C;
    end else begin
      motor_rated_current = {6'h00, motor_capacity_select} * 11'h005 +
        11'h006;
      rated_slip_frequency = 10'h0FA - {5'h00, motor_capacity_select} *
        10'h006;
      // 40 percent of rated current as the no-load guess
      no_load_current = {5'h00, motor_capacity_select} * 10'h002 + 10'h003;
      motor_efficiency_setting = 7'h3C + {2'h0, motor_capacity_select};
    end
  end

endmodule

// ===== core/three_wire_latch.v
// three-wire push-button run latch
// assumes: inputs already synchronised to clk_sys
`timescale 1ns/1ns
`include "drive_run_defs.vh"

module three_wire_latch (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // control
  input wire enable,
  input wire run_button,
  input wire stop_level,
  // state
  output reg run_latched
);

  // a stop level held low always wins over a run press in the same cycle
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_latched <= 1'b0;
    end else if (!enable || !stop_level) begin
      run_latched <= 1'b0;
    end else if (run_button) begin
      run_latched <= 1'b1;
    end
  end

endmodule

// ===== core/drive_run_sequencer.v
// run-command sequencer: three-wire latch, dwell stage, slip compensation
// assumes: terminals are raw pins from push buttons; settings are static
// levels from the parameter store on clk_sys
`timescale 1ns/1ns
`include "drive_run_defs.vh"

module drive_run_sequencer #(
  parameter num_terminals = `ADVANCED_IO_TERMINALS,
  parameter freq_w = 16,
  parameter dwell_tick_cyc = `DWELL_TICK_CYC,
  parameter pulse_min_cyc = `PULSE_MIN_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // terminals and their function codes, five bits each, terminal 1 low
  input wire [num_terminals-1:0] input_terminals,
  input wire [5*num_terminals-1:0] terminal_function_codes,
  input wire fwd_run_button,
  // dwell configuration, frequency in 0.01 Hz, time in 0.1 s
  input wire [freq_w-1:0] dwell_frequency_setting,
  input wire [6:0] dwell_time_setting,
  // frequency command and acceleration
  input wire [freq_w-1:0] target_frequency,
  input wire [freq_w-1:0] accel_step,
  // slip compensation configuration
  input wire [1:0] control_method_select,
  input wire [4:0] motor_capacity_select,
  input wire [1:0] load_inertia_select,
  input wire [9:0] load_percent,
  // status and command out
  output reg run_command,
  output reg dwell_active,
  output reg three_wire_mode,
  output reg three_wire_pulse_short,
  output reg slip_comp_on,
  output reg [1:0] inertia_class,
  output reg [freq_w-1:0] output_frequency,
  output reg [10:0] motor_rated_current,
  output reg [9:0] rated_slip_frequency,
  output reg [9:0] no_load_current,
  output reg [6:0] motor_efficiency_setting
);

  localparam st_stop = 2'b00;
  localparam st_dwell = 2'b01;
  localparam st_accel = 2'b10;
  localparam st_run = 2'b11;

  reg [num_terminals-1:0] term_meta;
  reg [num_terminals-1:0] term_sync;
  reg run_meta;
  reg run_sync;
  reg [num_terminals-1:0] is_three_wire;
  reg tw_sel_level;
  reg tw_any;
  wire run_latched;
  reg [1:0] state;
  reg [1:0] next_state;
  reg dwell_used;
  reg [23:0] tick_cnt;
  reg [6:0] tenth_cnt;
  reg [23:0] pulse_cnt;
  reg run_prev;
  wire [10:0] def_current;
  wire [9:0] def_slip;
  wire [9:0] def_noload;
  wire [6:0] def_eff;
  reg [freq_w-1:0] base_freq;
  reg [freq_w-1:0] slip_add;
  reg [19:0] slip_prod;
  reg [19:0] slip_quot;
  reg [freq_w:0] freq_sum;
  reg [freq_w-1:0] freq_next;
  integer k;
  genvar g;

  // two-stage synchronisers for push-button pins
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      term_meta <= {num_terminals{1'b0}};
      term_sync <= {num_terminals{1'b0}};
      run_meta <= 1'b0;
      run_sync <= 1'b0;
    end else begin
      term_meta <= input_terminals;
      term_sync <= term_meta;
      run_meta <= fwd_run_button;
      run_sync <= run_meta;
    end
  end

  // any terminal may carry the three-wire code
  generate
    for (g = 0; g < num_terminals; g = g + 1) begin : tw_decode
      always @* begin
        is_three_wire[g] =
          (terminal_function_codes[5*g +: 5] == `FUNC_THREE_WIRE);
      end
    end
  endgenerate

  // lowest-numbered terminal wins if several carry the code
  always @* begin
    tw_any = 1'b0;
    tw_sel_level = 1'b0;
    for (k = num_terminals - 1; k >= 0; k = k - 1) begin
      if (is_three_wire[k]) begin
        tw_any = 1'b1;
        tw_sel_level = term_sync[k];
      end
    end
  end

  three_wire_latch u_latch (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(tw_any),
    .run_button(run_sync),
    .stop_level(tw_sel_level),
    .run_latched(run_latched)
  );

  // flags three-wire presses shorter than the minimum the operator circuit must give
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pulse_cnt <= 24'h000000;
      run_prev <= 1'b0;
      three_wire_pulse_short <= 1'b0;
    end else begin
      run_prev <= run_sync;
      if (run_sync) begin
        if (pulse_cnt < pulse_min_cyc) begin
          pulse_cnt <= pulse_cnt + 24'h000001;
        end
      end else begin
        pulse_cnt <= 24'h000000;
      end
      if (run_prev && !run_sync && tw_any) begin
        three_wire_pulse_short <= (pulse_cnt < pulse_min_cyc);
      end
    end
  end

  // without three-wire, the run button is a plain level command
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_command <= 1'b0;
      three_wire_mode <= 1'b0;
    end else begin
      three_wire_mode <= tw_any;
      run_command <= tw_any ? run_latched : run_sync;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      st_stop: begin
        if (run_command) begin
          if (!dwell_used && dwell_time_setting != 7'h00 &&
              dwell_frequency_setting != {freq_w{1'b0}}) begin
            next_state = st_dwell;
          end else begin
            next_state = st_accel;
          end
        end
      end
      st_dwell: begin
        if (!run_command) begin
          next_state = st_stop;
        end else if (tenth_cnt >= dwell_time_setting) begin
          next_state = st_accel;
        end
      end
      st_accel: begin
        if (!run_command) begin
          next_state = st_stop;
        end else if (base_freq == target_frequency) begin
          // the ramp lands exactly on target, rising or falling
          next_state = st_run;
        end
      end
      st_run: begin
        if (!run_command) begin
          next_state = st_stop;
        end else if (base_freq != target_frequency) begin
          next_state = st_accel;
        end
      end
      default: begin
        next_state = st_stop;
      end
    endcase
  end

  // dwell counts 0.1 s ticks; dwell_used remembers the first acceleration
  // until the run command is seen low in the stop state
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= st_stop;
      tick_cnt <= 24'h000000;
      tenth_cnt <= 7'h00;
      dwell_used <= 1'b0;
      dwell_active <= 1'b0;
      base_freq <= {freq_w{1'b0}};
    end else begin
      state <= next_state;
      dwell_active <= (next_state == st_dwell);
      if (state == st_dwell) begin
        if (tick_cnt >= dwell_tick_cyc - 1) begin
          tick_cnt <= 24'h000000;
          tenth_cnt <= tenth_cnt + 7'h01;
        end else begin
          tick_cnt <= tick_cnt + 24'h000001;
        end
      end else begin
        tick_cnt <= 24'h000000;
        tenth_cnt <= 7'h00;
      end
      if (state == st_stop && run_command) begin
        dwell_used <= 1'b1;
      end else if (!run_command && state == st_stop) begin
        dwell_used <= 1'b0;
      end
      case (next_state)
        st_dwell: begin
          base_freq <= dwell_frequency_setting;
        end
        st_accel: begin
          if (target_frequency - base_freq > accel_step &&
              base_freq < target_frequency) begin
            base_freq <= base_freq + accel_step;
          end else if (base_freq > target_frequency &&
              base_freq - target_frequency > accel_step) begin
            base_freq <= base_freq - accel_step;
          end else begin
            base_freq <= target_frequency;
          end
        end
        st_run: begin
          base_freq <= target_frequency;
        end
        default: begin
          base_freq <= {freq_w{1'b0}};
        end
      endcase
    end
  end

  motor_defaults u_defaults (
    .motor_capacity_select(motor_capacity_select),
    .motor_rated_current(def_current),
    .rated_slip_frequency(def_slip),
    .no_load_current(def_noload),
    .motor_efficiency_setting(def_eff)
  );

  // slip added in proportion to load, 100 percent load adds rated slip
  always @* begin
    slip_prod = {10'h000, def_slip} * {10'h000, load_percent};
    slip_quot = slip_prod / `LOAD_FULL_PCT;
    slip_add = {freq_w{1'b0}};
    if (control_method_select == `CTRL_SLIP_COMP &&
        base_freq != {freq_w{1'b0}}) begin
      // quotient stays below 2^12; freq_w must not exceed 20
      slip_add = slip_quot[freq_w-1:0];
    end
  end

  // saturate rather than wrap to a low frequency near full scale
  always @* begin
    freq_sum = {1'b0, base_freq} + {1'b0, slip_add};
    if (freq_sum[freq_w]) begin
      freq_next = {freq_w{1'b1}};
    end else begin
      freq_next = freq_sum[freq_w-1:0];
    end
  end

  // defaults are re-sampled so the outputs come from flip-flops
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slip_comp_on <= 1'b0;
      inertia_class <= `INERTIA_LOW;
      output_frequency <= {freq_w{1'b0}};
      motor_rated_current <= 11'h000;
      rated_slip_frequency <= 10'h000;
      no_load_current <= 10'h000;
      motor_efficiency_setting <= 7'h00;
    end else begin
      slip_comp_on <= (control_method_select == `CTRL_SLIP_COMP);
      case (load_inertia_select)
        2'h0: inertia_class <= `INERTIA_LOW;
        2'h1: inertia_class <= `INERTIA_TEN;
        default: inertia_class <= `INERTIA_HIGH;
      endcase
      output_frequency <= freq_next;
      motor_rated_current <= def_current;
      rated_slip_frequency <= def_slip;
      no_load_current <= def_noload;
      motor_efficiency_setting <= def_eff;
    end
  end

endmodule

// ===== sim/operator_panel.sv
// operator panel: run push button and the stop terminal of a 3-wire loop
// assumes: the bench calls its tasks; pins move 5 ns after a clk_sys rise
`timescale 1ns/1ns
module operator_panel (
  // clock
  input wire clk_sys,
  // buttons
  output reg run_button,
  output reg stop_terminal
);
  initial begin
    run_button = 1'b0;
    stop_terminal = 1'b0;
  end
  // press length is the caller's; below the drive's minimum it still latches but is flagged short
  task press(input integer n);
    begin
      @(posedge clk_sys);
      #5 run_button = 1'b1;
      repeat (n) @(posedge clk_sys);
      #5 run_button = 1'b0;
    end
  endtask
  task stop_level(input v);
    begin
      @(posedge clk_sys);
      #5 stop_terminal = v;
    end
  endtask
endmodule

// ===== sim/drive_run_properties.sv
// concurrent checks on the run sequencer's ports
// assumes: bound into drive_run_sequencer; one clock domain
`timescale 1ns/1ns
module drive_run_properties #(
  parameter num_terminals = 5,
  parameter freq_w = 16,
  parameter dwell_tick_cyc = 10,
  parameter pulse_min_cyc = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // inputs
  input wire [num_terminals-1:0] input_terminals,
  input wire [5*num_terminals-1:0] terminal_function_codes,
  input wire fwd_run_button,
  input wire [freq_w-1:0] dwell_frequency_setting,
  input wire [6:0] dwell_time_setting,
  input wire [freq_w-1:0] target_frequency,
  input wire [freq_w-1:0] accel_step,
  input wire [1:0] control_method_select,
  input wire [4:0] motor_capacity_select,
  input wire [1:0] load_inertia_select,
  input wire [9:0] load_percent,
  // outputs
  input wire run_command,
  input wire dwell_active,
  input wire three_wire_mode,
  input wire three_wire_pulse_short,
  input wire slip_comp_on,
  input wire [1:0] inertia_class,
  input wire [freq_w-1:0] output_frequency,
  input wire [10:0] motor_rated_current,
  input wire [9:0] rated_slip_frequency,
  input wire [9:0] no_load_current,
  input wire [6:0] motor_efficiency_setting
);
  reg dwell_used;
  wire tw_top;
  wire stop_pin;
  // only the top terminal is judged here, lower codes must all be zero
  assign tw_top = terminal_function_codes[5*num_terminals-1 -: 5] == 5'h11
    && terminal_function_codes[5*num_terminals-6:0] == 0;
  assign stop_pin = input_terminals[num_terminals-1];
  // clears early on purpose: the check then only blames certain repeats
  always @(posedge clk_sys or posedge reset) begin
    if (reset) dwell_used <= 1'b0;
    else if (!run_command) dwell_used <= 1'b0;
    else if (dwell_active) dwell_used <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_dwell_skip: assert property (
    dwell_active |-> dwell_time_setting != 0 && dwell_frequency_setting != 0)
    else $error("dwell with a zero setting");
  a_dwell_level: assert property (
    dwell_active && $past(dwell_active) && !slip_comp_on
    |-> output_frequency == dwell_frequency_setting)
    else $error("dwell frequency not output");
  a_dwell_start: assert property (
    $rose(run_command) && dwell_time_setting != 0 && output_frequency == 0
    && dwell_frequency_setting != 0 |-> ##[1:3] dwell_active)
    else $error("dwell did not start");
  a_dwell_once: assert property (
    $rose(dwell_active) |-> !dwell_used) else $error("second dwell");
  a_slip_select: assert property (
    $stable(control_method_select)[*3]
    |-> slip_comp_on == (control_method_select == 2'h1))
    else $error("slip enable wrong");
  a_inertia_map: assert property (
    $stable(load_inertia_select)[*3] |-> inertia_class ==
    (load_inertia_select == 2'h3 ? 2'h2 : load_inertia_select))
    else $error("inertia class wrong");
  a_mode_select: assert property (
    $stable(terminal_function_codes)[*3] && tw_top |-> three_wire_mode)
    else $error("three-wire mode missing");
  a_latch_hold: assert property (
    (tw_top && three_wire_mode && stop_pin)[*4] ##0 run_command
    |=> run_command) else $error("latched run lost");
  a_stop_clear: assert property (
    (tw_top && !stop_pin)[*5] |-> !run_command)
    else $error("run kept with stop low");
endmodule
bind drive_run_sequencer drive_run_properties #(
  .num_terminals(num_terminals),
  .freq_w(freq_w),
  .dwell_tick_cyc(dwell_tick_cyc),
  .pulse_min_cyc(pulse_min_cyc)
) i_drive_run_properties (.*);

// ===== sim/tb_drive_run_sequencer.sv
// bench for the run sequencer: 3-wire latch, dwell, slip settings
// assumes: operator_panel drives the run button and terminal five
`timescale 1ns/1ns
module tb_drive_run_sequencer;
  localparam tick = 10;
  localparam pmin = 8;
  reg clk_sys, reset;
  reg [3:0] low_terms;
  reg [24:0] codes;
  reg [15:0] dw_freq, target, accel;
  reg [6:0] dw_time;
  reg [1:0] ctrl, inertia;
  reg [4:0] cap;
  reg [9:0] load;
  reg [10:0] cur_small;
  wire run_button, stop_terminal, run_command, dwell_active;
  wire three_wire_mode, pulse_short, slip_comp_on;
  wire [1:0] inertia_class;
  wire [15:0] output_frequency;
  wire [10:0] rated_current;
  wire [9:0] slip_rated, no_load;
  wire [6:0] efficiency;
  integer err_count, checks, cycles, i;
  operator_panel i_operator_panel (.clk_sys(clk_sys),
    .run_button(run_button), .stop_terminal(stop_terminal));
  drive_run_sequencer #(.dwell_tick_cyc(tick), .pulse_min_cyc(pmin))
  i_drive_run_sequencer (.clk_sys(clk_sys), .reset(reset),
    .input_terminals({stop_terminal, low_terms}),
    .terminal_function_codes(codes), .fwd_run_button(run_button),
    .dwell_frequency_setting(dw_freq), .dwell_time_setting(dw_time),
    .target_frequency(target), .accel_step(accel),
    .control_method_select(ctrl), .motor_capacity_select(cap),
    .load_inertia_select(inertia), .load_percent(load),
    .run_command(run_command), .dwell_active(dwell_active),
    .three_wire_mode(three_wire_mode), .three_wire_pulse_short(pulse_short),
    .slip_comp_on(slip_comp_on), .inertia_class(inertia_class),
    .output_frequency(output_frequency), .motor_rated_current(rated_current),
    .rated_slip_frequency(slip_rated), .no_load_current(no_load),
    .motor_efficiency_setting(efficiency));
  task complete_run;
    begin
      if (err_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #5;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // a hang is cut short well past the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  initial begin
    reset = 1'b1;
    low_terms = 4'h0;
    codes = 25'h0000000;
    dw_freq = 16'h01F4;
    dw_time = 7'h05;
    target = 16'h1000;
    accel = 16'h0100;
    ctrl = 2'h0;
    cap = 5'h01;
    inertia = 2'h0;
    load = 10'h000;
    err_count = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    #5 reset = 1'b0;
    cyc(3);
    chk(output_frequency, 0);
    for (i = 0; i < 4; i = i + 1) begin
      ctrl = i[1:0];
      inertia = i[1:0];
      cyc(3);
      chk(slip_comp_on, i == 1);
      chk(inertia_class, i == 3 ? 2 : i);
    end
    ctrl = 2'h0;
    cur_small = rated_current;
    cap = 5'h16;
    cyc(3);
    chk(rated_current != cur_small, 1);
    chk(efficiency >= 50 && efficiency <= 100, 1);
    chk(slip_rated != 0 && slip_rated <= 1000, 1);
    // default no-load current within 0.1 A of 40 percent of rated
    chk(no_load * 10 + 10 >= rated_current * 4, 1);
    chk(no_load * 10 <= rated_current * 4 + 10, 1);
    // no three-wire terminal: run follows the button level
    fork
      i_operator_panel.press(12);
      begin
        cyc(6);
        chk(run_command, 1);
      end
    join
    cyc(5);
    chk(run_command, 0);
    cyc(30);
    codes = {5'h11, 20'h00000};
    cyc(3);
    chk(three_wire_mode, 1);
    i_operator_panel.stop_level(1'b1);
    cyc(3);
    i_operator_panel.press(pmin + 2);
    cyc(4);
    chk(run_command, 1);
    chk(pulse_short, 0);
    chk(dwell_active, 1);
    chk(output_frequency, 16'h01F4);
    cyc(tick * 5 + 5);
    chk(dwell_active, 0);
    cyc(20);
    chk(output_frequency, 16'h1000);
    accel = 16'h0080;
    target = 16'h0000;
    cyc(8);
    chk(output_frequency, 16'h0C80);
    cyc(32);
    chk(output_frequency, 0);
    accel = 16'h0100;
    target = 16'h1000;
    cyc(3);
    chk(dwell_active, 0);
    ctrl = 2'h1;
    load = 10'h064;
    cyc(25);
    chk(output_frequency > 16'h1000, 1);
    ctrl = 2'h0;
    load = 10'h000;
    i_operator_panel.stop_level(1'b0);
    cyc(5);
    chk(run_command, 0);
    cyc(40);
    i_operator_panel.stop_level(1'b1);
    cyc(3);
    i_operator_panel.press(3);
    cyc(4);
    chk(pulse_short, 1);
    i_operator_panel.stop_level(1'b0);
    cyc(40);
    for (i = 0; i < 2; i = i + 1) begin
      dw_time = (i == 1) ? 7'h05 : 7'h00;
      dw_freq = (i == 1) ? 16'h0000 : 16'h01F4;
      i_operator_panel.stop_level(1'b1);
      cyc(3);
      i_operator_panel.press(pmin + 2);
      cyc(2);
      chk(run_command, 1);
      chk(dwell_active, 0);
      i_operator_panel.stop_level(1'b0);
      cyc(40);
    end
    codes = {20'h00000, 5'h11};
    low_terms = 4'h1;
    cyc(3);
    i_operator_panel.press(pmin + 2);
    cyc(4);
    chk(three_wire_mode, 1);
    chk(run_command, 1);
    low_terms = 4'h0;
    cyc(5);
    chk(run_command, 0);
    complete_run;
  end
endmodule
